/* File: hw/ssm_top.sv */
// Serial mode select, enable, data register and SPI shifter behind an APB slave
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module ssm_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SUB_TICK,
  input wire logic TIMER_MATCH,
  input wire logic SCK_IN,
  input wire logic SDI_IN,
  input wire logic SCS_N_IN,
  output logic SCK_OUT,
  output logic SCK_OE_N,
  output logic SDO_OUT,
  output logic SDO_OE_N,
  output logic UART_MODE,
  output logic TWO_WIRE_MODE,
  output logic [1:0] DEBOUNCE_SEL,
  output logic TWO_WIRE_FLAG_CLEAR,
  output logic IRQ
);
  // Software-visible registers; only the low byte of each bus word is used
  logic [7:0] mode_control;
  logic [7:0] aux_control;
  logic [7:0] shift_data;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;

  // Pin synchroniser stages and the edge history of the settled levels
  logic [1:0] sck_sync, scs_sync, sdi_sync;
  logic sck_prev, scs_prev;

  // Master rate generation
  logic [5:0] div_count;
  logic timer_half;

  // Shift engine state
  logic busy;
  logic [3:0] bit_count;
  logic sck_level;

  // Enable history, for the two-wire flag reset pulse
  logic enable_prev;

  // Next pin values, registered once more before they leave
  ssm_pkg::ssm_pins_t pins;

  // Decoded mode; UART bit overrides the field
  // Code 111, two-wire and UART mode leave every SPI path idle, so a
  // data write there stores the byte but never arms the shifter
  ssm_pkg::ssm_mode_t mode;
  logic enabled, spi_master, spi_slave, two_wire;
  assign mode = ssm_pkg::ssm_mode_t'(mode_control[ssm_pkg::MODE_LSB +: 3]);
  assign enabled = mode_control[ssm_pkg::ENABLE_POS];
  assign spi_master = enabled && !mode_control[ssm_pkg::UART_SEL_POS] &&
                      (mode <= ssm_pkg::MODE_MASTER_TIMER);
  assign spi_slave = enabled && !mode_control[ssm_pkg::UART_SEL_POS] &&
                     (mode == ssm_pkg::MODE_SLAVE);
  assign two_wire = enabled && !mode_control[ssm_pkg::UART_SEL_POS] &&
                    (mode == ssm_pkg::MODE_TWO_WIRE);

  // Select pin in use
  logic select_pin_enable;
  assign select_pin_enable = aux_control[ssm_pkg::AUX_SELECT_PIN_ENABLE_POS];

  // APB decode
  // Reads are latched at the setup edge, writes land at the access edge
  logic wr, rd;
  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && PENABLE && !PWRITE;

  // Unmapped words answer with an error and ignore writes
  logic mapped;
  assign mapped = (PADDR == ssm_pkg::ADDR_MODE_CONTROL) || (PADDR == ssm_pkg::ADDR_SHIFT_DATA) ||
                  (PADDR == ssm_pkg::ADDR_AUX_CONTROL) || (PADDR == ssm_pkg::ADDR_IRQ_STATUS) ||
                  (PADDR == ssm_pkg::ADDR_IRQ_MASK) || (PADDR == ssm_pkg::ADDR_LINK_STATUS);

  // Pin synchronisers; only the second stage is read
  // Select resets high, its idle level, so no false release follows reset
  always_ff @(posedge CLK) begin
    if (RST) begin
      sck_sync <= 2'h0;
      scs_sync <= 2'h3;
      sdi_sync <= 2'h0;
    end else begin
      sck_sync <= {sck_sync[0], SCK_IN};
      scs_sync <= {scs_sync[0], SCS_N_IN};
      sdi_sync <= {sdi_sync[0], SDI_IN};
    end
  end

  // Settled pin levels
  logic sck_s, scs_s, sdi_s;
  assign sck_s = sck_sync[1];
  assign scs_s = scs_sync[1];
  assign sdi_s = sdi_sync[1];

  // Edge history; previous levels reset to the idle pin levels
  // Timer match toggles a half flag so only every second match ticks
  always_ff @(posedge CLK) begin
    if (RST) begin
      sck_prev <= 1'b0;
      scs_prev <= 1'b1;
      timer_half <= 1'b0;
      enable_prev <= 1'b0;
    end else begin
      sck_prev <= sck_s;
      scs_prev <= scs_s;
      enable_prev <= enabled;
      if (TIMER_MATCH) begin
        timer_half <= !timer_half;
      end
    end
  end

  // Slave edges and select state; select enable low means always selected
  logic slave_rise, slave_fall, scs_rise, scs_low;
  assign slave_rise = sck_s && !sck_prev;
  assign slave_fall = !sck_s && sck_prev;
  assign scs_rise = scs_s && !scs_prev;
  assign scs_low = !select_pin_enable || !scs_s;

  // Master half-period tick from the selected rate
  // Sub clock and timer ticks come from this clock domain, no sync needed
  logic half_tick;
  always_comb begin
    case (mode)
      ssm_pkg::MODE_MASTER_DIV4: half_tick = (div_count >= ssm_pkg::DIV4_HALF);
      ssm_pkg::MODE_MASTER_DIV16: half_tick = (div_count >= ssm_pkg::DIV16_HALF);
      ssm_pkg::MODE_MASTER_DIV64: half_tick = (div_count >= ssm_pkg::DIV64_HALF);
      ssm_pkg::MODE_MASTER_SUB: half_tick = SUB_TICK;
      ssm_pkg::MODE_MASTER_TIMER: half_tick = TIMER_MATCH && timer_half;
      default: half_tick = 1'b0;
    endcase
  end

  // Divider restarts at every tick and rests while idle, so each divided-rate
  // frame starts with a full first half period
  always_ff @(posedge CLK) begin
    if (RST || !busy || half_tick) begin
      div_count <= 6'h00;
    end else begin
      div_count <= div_count + 6'h01;
    end
  end

  // Data register write; arms the shifter only in an SPI mode
  logic data_write;
  assign data_write = wr && (PADDR == ssm_pkg::ADDR_SHIFT_DATA);
  // Select released mid-frame; only counts while the select pin is in use
  logic early_release;
  assign early_release = spi_slave && select_pin_enable && busy && scs_rise;

  // Shift engine: eight bits full duplex, MSB first
  // The slave samples its input on the clock rise; the master takes its
  // input at its own fall instead, since the output register and the
  // input synchroniser put three cycles between a launched edge and the
  // returning bit, more than a half period at the fastest rate
  logic frame_done;
  logic master_rise, master_fall;
  assign master_rise = spi_master && busy && half_tick && !sck_level;
  assign master_fall = spi_master && busy && half_tick && sck_level;

  // Sample and shift strobes, master or slave
  logic samp, shft;
  assign samp = master_rise || (spi_slave && scs_low && slave_rise);
  assign shft = master_fall || (spi_slave && scs_low && slave_fall);
  assign frame_done = shft && (bit_count == ssm_pkg::BITS_PER_FRAME);
  // Slave input bit held from the rise to the following fall
  logic sample_bit;
  always_ff @(posedge CLK) begin
    if (RST) begin
      shift_data <= ssm_pkg::SHIFT_DATA_RESET;
      sample_bit <= 1'b0;
      bit_count <= 4'h0;
      busy <= 1'b0;
      sck_level <= 1'b0;
    end else if (!enabled) begin
      // Disabled: shifter idles, data register stays writable
      busy <= 1'b0;
      bit_count <= 4'h0;
      sck_level <= 1'b0;
      if (data_write) begin
        shift_data <= PWDATA[7:0];
      end
    end else if (data_write && !busy) begin
      // A write while busy falls through and is dropped
      shift_data <= PWDATA[7:0];
      busy <= spi_master || spi_slave;
      bit_count <= 4'h0;
    end else if (early_release) begin
      // Cut frame: drop the partial bit count, keep the data register
      busy <= 1'b0;
      bit_count <= 4'h0;
    end else begin
      // A slave frame also starts on the first clock with no write
      if (spi_slave && !busy && scs_low && slave_rise) begin
        busy <= 1'b1;
      end
      if (spi_master && half_tick && busy) begin
        sck_level <= !sck_level;
      end
      if (samp) begin
        sample_bit <= sdi_s;
        bit_count <= bit_count + 4'h1;
      end
      if (shft && bit_count != 4'h0) begin
        shift_data <= {shift_data[6:0], spi_master ? sdi_s : sample_bit};
        if (frame_done) begin
          busy <= 1'b0;
          bit_count <= 4'h0;
        end
      end
    end
  end

  // Mode control register; enable rise keeps SPI controls
  always_ff @(posedge CLK) begin
    if (RST) begin
      mode_control <= ssm_pkg::MODE_CONTROL_RESET;
    end else begin
      // Software stores the incomplete bit as written; done is untouched
      if (wr && PADDR == ssm_pkg::ADDR_MODE_CONTROL) begin
        mode_control <= PWDATA[7:0];
      end
      // After the write, so a hardware set wins
      if (early_release) begin
        mode_control[ssm_pkg::INCOMPLETE_POS] <= 1'b1;
      end
    end
  end

  // Aux control: transfer done flag; set wins over software clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      aux_control <= ssm_pkg::AUX_CONTROL_RESET;
    end else begin
      if (wr && PADDR == ssm_pkg::ADDR_AUX_CONTROL) begin
        aux_control <= PWDATA[7:0];
      end
      // A finished or cut frame sets done; a software write stores bit 0 as written
      if (frame_done || early_release) begin
        aux_control[ssm_pkg::AUX_TRF_POS] <= 1'b1;
      end
    end
  end

  // Interrupt status, cleared by read; set wins
  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_status <= ssm_pkg::IRQ_RESET;
      irq_mask <= ssm_pkg::IRQ_RESET;
    end else begin
      if (wr && PADDR == ssm_pkg::ADDR_IRQ_MASK) begin
        irq_mask <= PWDATA[1:0];
      end
      // Clear only the bits the read returned: the word was latched at the
      // setup edge, and an event in between must survive the read
      irq_status <= ((rd && PADDR == ssm_pkg::ADDR_IRQ_STATUS) ?
                     (irq_status & ~PRDATA[1:0]) : irq_status) |
                    {early_release, frame_done || early_release};
    end
  end

  // Pin drive; released while disabled or not driving
  // The clock pin is only ever driven as master, never in slave mode
  always_comb begin
    pins.sck_out = sck_level;
    pins.sck_oe_n = !spi_master;
    pins.sdo_out = shift_data[7];
    pins.sdo_oe_n = !(spi_master || (spi_slave && scs_low));
  end

  // Registered outputs
  // Every pin and mode output leaves through a flop; one cycle of latency
  always_ff @(posedge CLK) begin
    if (RST) begin
      SCK_OUT <= 1'b0;
      SCK_OE_N <= 1'b1;
      SDO_OUT <= 1'b0;
      SDO_OE_N <= 1'b1;
      UART_MODE <= 1'b0;
      TWO_WIRE_MODE <= 1'b0;
      DEBOUNCE_SEL <= 2'h0;
      TWO_WIRE_FLAG_CLEAR <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      SCK_OUT <= pins.sck_out;
      SCK_OE_N <= pins.sck_oe_n;
      SDO_OUT <= pins.sdo_out;
      SDO_OE_N <= pins.sdo_oe_n;
      UART_MODE <= enabled && mode_control[ssm_pkg::UART_SEL_POS];
      TWO_WIRE_MODE <= two_wire;
      DEBOUNCE_SEL <= two_wire ? mode_control[ssm_pkg::DEB_LSB +: 2] : 2'h0;
      TWO_WIRE_FLAG_CLEAR <= two_wire && !enable_prev;
      IRQ <= |(irq_status & irq_mask);
    end
  end

  // APB read and answer, zero wait states
  // Read data is latched at the setup edge and stands for the access cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      PRDATA <= 32'h0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !mapped;
      PRDATA <= 32'h0;
      if (PSEL && !PENABLE) begin
        case (PADDR)
          ssm_pkg::ADDR_MODE_CONTROL: PRDATA <= {24'h0, mode_control};
          ssm_pkg::ADDR_SHIFT_DATA: PRDATA <= {24'h0, shift_data};
          ssm_pkg::ADDR_AUX_CONTROL: PRDATA <= {24'h0, aux_control};
          ssm_pkg::ADDR_IRQ_STATUS: PRDATA <= {30'h0, irq_status};
          ssm_pkg::ADDR_IRQ_MASK: PRDATA <= {30'h0, irq_mask};
          ssm_pkg::ADDR_LINK_STATUS: PRDATA <= {28'h0, bit_count[3], busy, scs_s, sck_s};
          default: PRDATA <= 32'h0;
        endcase
      end
    end
  end
endmodule

/* File: include/ssm_pkg.sv */
// Package with register map, field positions and constants of the serial mode block
package ssm_pkg;
  // Register byte addresses (32-bit aligned words)
  localparam logic [7:0] ADDR_MODE_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_SHIFT_DATA = 8'h04;
  localparam logic [7:0] ADDR_AUX_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_LINK_STATUS = 8'h14;

  // Mode control field positions
  localparam int MODE_LSB = 5;
  localparam int UART_SEL_POS = 4;
  localparam int DEB_LSB = 2;
  localparam int ENABLE_POS = 1;
  localparam int INCOMPLETE_POS = 0;
  // Aux control field positions
  localparam int AUX_SELECT_PIN_ENABLE_POS = 2;
  localparam int AUX_TRF_POS = 0;
  // Interrupt status bits
  localparam int IRQ_DONE_POS = 0;
  localparam int IRQ_INCOMPLETE_POS = 1;

  // Reset values
  localparam logic [7:0] MODE_CONTROL_RESET = 8'he0;
  localparam logic [7:0] AUX_CONTROL_RESET = 8'h00;
  localparam logic [7:0] SHIFT_DATA_RESET = 8'h00;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // Clock divider counts for master rates
  localparam logic [5:0] DIV4_HALF = 6'h01;
  localparam logic [5:0] DIV16_HALF = 6'h07;
  localparam logic [5:0] DIV64_HALF = 6'h1f;
  localparam logic [3:0] BITS_PER_FRAME = 4'h8;

  typedef enum logic [2:0] {
    MODE_MASTER_DIV4,
    MODE_MASTER_DIV16,
    MODE_MASTER_DIV64,
    MODE_MASTER_SUB,
    MODE_MASTER_TIMER,
    MODE_SLAVE,
    MODE_TWO_WIRE,
    MODE_UNUSED
  } ssm_mode_t;

  // Serial pin bundle: output and enable for each pin (enable active low)
  typedef struct packed {
    logic sck_out;
    logic sck_oe_n;
    logic sdo_out;
    logic sdo_oe_n;
  } ssm_pins_t;
endpackage

/* File: verification/ssm_chk.sv */
// Checker of bus, mode and pin relations at the serial mode block ports
`timescale 1ns/1ps
module ssm_chk (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SCK_OUT,
  input wire logic SCK_OE_N,
  input wire logic SDO_OE_N,
  input wire logic UART_MODE,
  input wire logic TWO_WIRE_MODE,
  input wire logic [1:0] DEBOUNCE_SEL,
  input wire logic TWO_WIRE_FLAG_CLEAR
);
  logic [7:0] mc;
  logic [3:0] sck_cnt;
  logic sck_d;
  wire w = PSEL && PENABLE && PWRITE && PREADY;
  wire en = mc[1];
  wire ua = mc[4];
  wire [2:0] md = mc[7:5];
  // Shadow of mode control; the bus is the only writer we can see
  always_ff @(posedge CLK) begin
    if (RST) mc <= 8'he0;
    else if (w && PADDR == 8'h00) mc <= PWDATA[7:0];
  end
  // Serial clock rises since the last data write, saturating
  always_ff @(posedge CLK) begin
    sck_d <= SCK_OUT;
    if (RST || (w && PADDR == 8'h04)) sck_cnt <= 4'h0;
    else if (SCK_OUT && !sck_d && sck_cnt != 4'hf) sck_cnt <= sck_cnt + 4'h1;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("ready late");
  a_slverr_map: assert property (PREADY |-> PSLVERR == (PADDR > 8'h14 || PADDR[1:0] != 2'h0))
    else $error("slverr wrong");
  a_pins_released: assert property (!en && !$past(en) |-> SCK_OE_N && SDO_OE_N)
    else $error("pins driven while off");
  a_slave_no_clk: assert property (md == 3'h5 && !ua && $past(md) == 3'h5 |-> SCK_OE_N)
    else $error("slave drives clock");
  a_uart_level: assert property (UART_MODE == $past(en && ua))
    else $error("uart level wrong");
  a_mode_gate: assert property ($past(ua || md != 3'h6) |-> !TWO_WIRE_MODE)
    else $error("two-wire not gated");
  a_deb_ignored: assert property ($past(ua || md != 3'h6) |-> DEBOUNCE_SEL == 2'h0)
    else $error("debounce leaks");
  a_flag_cause: assert property (TWO_WIRE_FLAG_CLEAR |-> $past(md == 3'h6 && !ua && en))
    else $error("flag clear stray");
  a_flag_pulse: assert property ($rose(en) && md == 3'h6 && !ua |-> ##[1:3] TWO_WIRE_FLAG_CLEAR)
    else $error("flag clear missing");
  a_eight_bits: assert property (sck_cnt <= 4'h8)
    else $error("too many clocks");
  cover property (sck_cnt == 4'h8);
  cover property (TWO_WIRE_FLAG_CLEAR);
  cover property (PREADY && PSLVERR);
endmodule
bind ssm_top ssm_chk u_ssm_chk (.*);

/* File: verification/ssm_peer.sv */
// External SPI peer: master when mst is high, slave otherwise
`timescale 1ns/1ps
module ssm_peer (
  input wire logic mst,
  input wire logic sck_out,
  input wire logic sdo,
  output logic sck,
  output logic sdi,
  output logic scs_n
);
  logic [7:0] sh = 8'h00;
  logic [7:0] rx = 8'h00;
  wire sclk = mst ? sck : sck_out;
  initial begin
    sck = 1'b0;
    scs_n = 1'b1;
  end
  assign sdi = sh[7];
  // Capture on rise, MSB first
  always @(posedge sclk) rx <= {rx[6:0], sdo};
  // Shift on fall; each refill bit is the inverse of bit 0 so stale data never lingers
  always @(negedge sclk) sh <= {sh[6:0], ~sh[0]};
  task automatic load(input logic [7:0] b);
    sh = b;
  endtask
  // Frame of n clocks at 48 ns; clock stands still outside frames
  task automatic frame(input int n);
    scs_n = 1'b0;
    #24;
    repeat (n) begin
      sck = 1'b1;
      #24;
      sck = 1'b0;
      #24;
    end
    scs_n = 1'b1;
    #48;
  endtask
endmodule

/* File: verification/ssm_top_test.sv */
// Self-checking bench of the serial mode block with its SPI peer
`timescale 1ns/1ps
module ssm_top_test;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic sub_tick = 1'b0, timer_match = 1'b0, mst = 1'b0, err;
  logic [3:0] tick = 4'h0;
  logic pready, pslverr, sck_in, sdi_in, scs_n_in, sck_out, sck_oe_n, sdo_out, sdo_oe_n;
  logic uart_mode, two_wire, flag_clr, irq;
  logic [1:0] deb;
  int error_cnt = 0;
  int comparisons = 0;
  wire sdo_w = sdo_oe_n ? 1'b1 : sdo_out;
  always #2.5 clk = ~clk;
  // Sub-clock tick each fourth cycle, timer match each second
  always @(posedge clk) begin
    tick <= tick + 4'h1;
    sub_tick <= tick[1:0] == 2'h0;
    timer_match <= tick[0];
  end
  ssm_top u_ssm_top (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SUB_TICK(sub_tick), .TIMER_MATCH(timer_match), .SCK_IN(sck_in), .SDI_IN(sdi_in),
    .SCS_N_IN(scs_n_in), .SCK_OUT(sck_out), .SCK_OE_N(sck_oe_n), .SDO_OUT(sdo_out),
    .SDO_OE_N(sdo_oe_n), .UART_MODE(uart_mode), .TWO_WIRE_MODE(two_wire),
    .DEBOUNCE_SEL(deb), .TWO_WIRE_FLAG_CLEAR(flag_clr), .IRQ(irq));
  ssm_peer u_ssm_peer (.mst(mst), .sck_out(sck_out), .sdo(sdo_w), .sck(sck_in),
    .sdi(sdi_in), .scs_n(scs_n_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) error_cnt++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Poll the done flag under a bound
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'h08, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 600);
  endtask
  task automatic t_reset();
    rchk(8'h00, 32'he0);
    rchk(8'h04, 32'h0);
    apb(1'b1, 8'h20, 32'hff);
    chk(32'(err), 32'h1);
    rchk(8'h20, 32'h0);
    chk({30'h0, sck_oe_n, sdo_oe_n}, 32'h3);
    $display("reset test done");
  endtask
  // Every master rate: full duplex byte each way
  task automatic t_master();
    for (int m = 0; m < 5; m++) begin
      apb(1'b1, 8'h00, {24'h0, m[2:0], 5'h02});
      u_ssm_peer.load(8'h5a ^ m[7:0]);
      apb(1'b1, 8'h04, {24'h0, 8'ha0 | m[7:0]});
      wait_done();
      chk(32'(rd[0]), 32'h1);
      rchk(8'h04, {24'h0, 8'h5a ^ m[7:0]});
      chk({24'h0, u_ssm_peer.rx}, {24'h0, 8'ha0 | m[7:0]});
      apb(1'b1, 8'h08, 32'h0);
    end
    $display("master test done");
  endtask
  task automatic t_slave();
    mst <= 1'b1;
    apb(1'b1, 8'h00, 32'ha2);
    apb(1'b1, 8'h04, 32'h96);
    u_ssm_peer.load(8'h5a);
    u_ssm_peer.frame(8);
    repeat (8) @(posedge clk);
    rchk(8'h08, 32'h1);
    rchk(8'h04, 32'h5a);
    chk({24'h0, u_ssm_peer.rx}, 32'h96);
    chk(32'(sck_oe_n), 32'h1);
    apb(1'b1, 8'h08, 32'h0);
    $display("slave test done");
  endtask
  // Select released after three bits; interrupt masked then cleared
  task automatic t_early();
    apb(1'b0, 8'h0c, 32'h0);
    apb(1'b1, 8'h10, 32'h3);
    apb(1'b1, 8'h08, 32'h4);
    apb(1'b1, 8'h04, 32'h33);
    u_ssm_peer.frame(3);
    repeat (8) @(posedge clk);
    rchk(8'h00, 32'ha3);
    rchk(8'h08, 32'h5);
    chk(32'(irq), 32'h1);
    apb(1'b1, 8'h10, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    apb(1'b1, 8'h10, 32'h3);
    rchk(8'h0c, 32'h3);
    rchk(8'h0c, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    apb(1'b1, 8'h08, 32'h0);
    $display("early release test done");
  endtask
  task automatic t_soft();
    apb(1'b1, 8'h00, 32'ha3);
    repeat (4) @(posedge clk);
    rchk(8'h08, 32'h0);
    rchk(8'h0c, 32'h0);
    rchk(8'h00, 32'ha3);
    $display("soft flag test done");
  endtask
  task automatic t_modes();
    apb(1'b1, 8'h08, 32'hc4);
    apb(1'b1, 8'h00, 32'hc0);
    apb(1'b1, 8'h00, 32'hce);
    repeat (2) @(posedge clk);
    chk(32'(flag_clr), 32'h1);
    @(posedge clk);
    chk(32'(flag_clr), 32'h0);
    chk({29'h0, two_wire, deb}, 32'h7);
    apb(1'b1, 8'h00, 32'h0e);
    repeat (3) @(posedge clk);
    chk({29'h0, two_wire, deb}, 32'h0);
    apb(1'b1, 8'h00, 32'hd2);
    repeat (3) @(posedge clk);
    chk({30'h0, uart_mode, two_wire}, 32'h2);
    apb(1'b1, 8'h00, 32'h00);
    repeat (3) @(posedge clk);
    chk({30'h0, sck_oe_n, sdo_oe_n}, 32'h3);
    apb(1'b1, 8'h00, 32'h02);
    rchk(8'h08, 32'hc4);
    $display("mode test done");
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_master();
    t_slave();
    t_early();
    t_soft();
    t_modes();
    test_done();
  end
  // Run needs about 1200 cycles; allow well over that
  initial begin
    #300000;
    error_cnt++;
    test_done();
  end
endmodule
